// ### shared/ser_pkg.sv
// shared constants and types for the status event reporting block
package ser_pkg;
	localparam int REG_W = 16;
	localparam int QPTR_W = 4;
	localparam int QDEPTH = 16;
	localparam int QDATA_W = 16;
	localparam logic [REG_W-1:0] REG_RST = 16'h0000;

	// word offsets, byte addressed
	localparam logic [7:0] OFF_STD_COND = 8'h00;
	localparam logic [7:0] OFF_STD_EVT = 8'h04;
	localparam logic [7:0] OFF_STD_EN = 8'h08;
	localparam logic [7:0] OFF_OPR_COND = 8'h0c;
	localparam logic [7:0] OFF_OPR_EVT = 8'h10;
	localparam logic [7:0] OFF_OPR_EN = 8'h14;
	localparam logic [7:0] OFF_MEA_COND = 8'h18;
	localparam logic [7:0] OFF_MEA_EVT = 8'h1c;
	localparam logic [7:0] OFF_MEA_EN = 8'h20;
	localparam logic [7:0] OFF_QUE_COND = 8'h24;
	localparam logic [7:0] OFF_QUE_EVT = 8'h28;
	localparam logic [7:0] OFF_QUE_EN = 8'h2c;
	localparam logic [7:0] OFF_STB = 8'h30;
	localparam logic [7:0] OFF_SRE = 8'h34;
	localparam logic [7:0] OFF_CMD = 8'h38;
	localparam logic [7:0] OFF_OUTQ = 8'h3c;
	localparam logic [7:0] OFF_ERRQ = 8'h40;
	localparam logic [7:0] OFF_IRQ_STAT = 8'h44;
	localparam logic [7:0] OFF_IRQ_MASK = 8'h48;

	// status byte bit positions
	localparam int STB_MEA = 0;
	localparam int STB_ERRQ = 2;
	localparam int STB_QUE = 3;
	localparam int STB_OUTQ = 4;
	localparam int STB_STD = 5;
	localparam int STB_SRQ = 6;
	localparam int STB_OPR = 7;

	// command register bits (write one to trigger)
	localparam int CMD_CLS = 0;
	localparam int CMD_STAT_PRESET = 1;
	localparam int CMD_QUEUE_CLEAR = 2;
	localparam int CMD_ERR_CLEAR = 3;
	localparam int CMD_SYS_PRESET = 4;
	localparam int CMD_RST = 5;

	// interrupt status bits
	localparam int IRQ_SRQ_RISE = 0;
	localparam int IRQ_OUTQ_OVF = 1;
	localparam int IRQ_ERRQ_OVF = 2;

	typedef struct packed {
		logic push;
		logic [QDATA_W-1:0] data;
	} ser_push_t;

	typedef struct packed {
		logic [REG_W-1:0] cond;
		logic [REG_W-1:0] evt;
		logic [REG_W-1:0] en;
	} ser_set_t;
endpackage

// ### hdl/ser_top.sv
// status event reporting: register sets, status byte, queues, wishbone slave
//
// Register access over Wishbone and the register offsets were chosen for this implementation.
`timescale 1ns/1ns
`default_nettype none

// Function
// - condition registers read-only, track live conditions
// - event bits latch until explicitly reset
// - set summary when enabled event bit set
// - status byte gathers four sets, two queues
// - enabled status byte bit raises service request
// - queue summary set while queue nonempty
// - responses to output queue, errors to error
// - power-up clears registers, empties both queues
// - writing zero clears that enable register
// - system preset and reset leave status alone
// - clear-status clears events and error queue
// - status preset clears three enable registers
// - standard enable cleared only by zero write or power-up
// - status preset keeps error queue contents
// - either clear command empties error queue
// - only enable, command and interrupt registers host writable
// - set registers sixteen bits, bit n weight two^n
module ser_top #(
	parameter int REG_W = ser_pkg::REG_W,
	parameter int QDEPTH = ser_pkg::QDEPTH,
	parameter int QPTR_W = ser_pkg::QPTR_W
) (
	input wire logic clk_in,
	input wire logic rst_n_in,
	input wire logic [31:0] wb_adr_in,
	input wire logic [31:0] wb_dat_in,
	input wire logic [3:0] wb_sel_in,
	input wire logic wb_we_in,
	input wire logic wb_cyc_in,
	input wire logic wb_stb_in,
	output logic [31:0] wb_dat_out,
	output logic wb_ack_out,
	input wire logic [REG_W-1:0] std_cond_in,
	input wire logic [REG_W-1:0] opr_cond_in,
	input wire logic [REG_W-1:0] mea_cond_in,
	input wire logic [REG_W-1:0] que_cond_in,
	input wire logic [REG_W-1:0] std_evt_in,
	input wire logic [REG_W-1:0] opr_evt_in,
	input wire logic [REG_W-1:0] mea_evt_in,
	input wire logic [REG_W-1:0] que_evt_in,
	input wire ser_pkg::ser_push_t outq_push_in,
	input wire ser_pkg::ser_push_t errq_push_in,
	output logic [7:0] status_byte_out,
	output logic service_request_summary_bit_out,
	output logic irq_out
);
	// =====================================================
	// bus decode
	logic acc;
	logic wr;
	logic rd;
	logic [7:0] adr;
	logic [15:0] wdat;
	logic lo_en;
	logic hi_en;
	assign acc = wb_cyc_in && wb_stb_in && !wb_ack_out;
	assign wr = acc && wb_we_in;
	assign rd = acc && !wb_we_in;
	assign adr = wb_adr_in[7:0];
	assign wdat = wb_dat_in[15:0];
	assign lo_en = wb_sel_in[0];
	assign hi_en = wb_sel_in[1];

	logic [ser_pkg::CMD_RST:0] cmd;
	assign cmd = (wr && adr == ser_pkg::OFF_CMD) ? wb_dat_in[ser_pkg::CMD_RST:0] : '0;

	logic cls;
	logic stat_preset;
	logic errq_clear;
	assign cls = cmd[ser_pkg::CMD_CLS];
	assign stat_preset = cmd[ser_pkg::CMD_STAT_PRESET];
	assign errq_clear = cls || cmd[ser_pkg::CMD_QUEUE_CLEAR] || cmd[ser_pkg::CMD_ERR_CLEAR];

	// =====================================================
	// register sets: 0 std, 1 opr, 2 mea, 3 que
	logic [3:0][REG_W-1:0] cond_live;
	logic [3:0][REG_W-1:0] evt_live;
	logic [3:0][7:0] off_en;
	logic [3:0][REG_W-1:0] cond_q;
	logic [3:0][REG_W-1:0] evt_q;
	logic [3:0][REG_W-1:0] en_q;
	logic [3:0] sum;
	assign cond_live = {que_cond_in, mea_cond_in, opr_cond_in, std_cond_in};
	assign evt_live = {que_evt_in, mea_evt_in, opr_evt_in, std_evt_in};
	assign off_en = {ser_pkg::OFF_QUE_EN, ser_pkg::OFF_MEA_EN, ser_pkg::OFF_OPR_EN,
		ser_pkg::OFF_STD_EN};

	genvar g;
	generate
		for (g = 0; g < 4; g++) begin : g_set
			always_ff @(posedge clk_in) begin
				if (!rst_n_in) begin
					cond_q[g] <= '0;
				end else begin
					cond_q[g] <= cond_live[g];
				end
			end

			always_ff @(posedge clk_in) begin
				if (!rst_n_in) begin
					evt_q[g] <= '0;
				end else if (cls) begin
					evt_q[g] <= evt_live[g];
				end else begin
					evt_q[g] <= evt_q[g] | evt_live[g];
				end
			end

			// only enables writable; zero write clears
			always_ff @(posedge clk_in) begin
				if (!rst_n_in) begin
					en_q[g] <= '0;
				end else if (wr && adr == off_en[g]) begin
					if (lo_en) begin
						en_q[g][7:0] <= wdat[7:0];
					end
					if (hi_en) begin
						en_q[g][REG_W-1:8] <= wdat[REG_W-1:8];
					end
				end else if (stat_preset && g != 0) begin
					en_q[g] <= '0;
				end
			end

			assign sum[g] = |(evt_q[g] & en_q[g]);
		end
	endgenerate

	// =====================================================
	// queues
	logic [QDEPTH-1:0][ser_pkg::QDATA_W-1:0] outq_mem;
	logic [QDEPTH-1:0][ser_pkg::QDATA_W-1:0] errq_mem;
	logic [QPTR_W:0] outq_cnt_q;
	logic [QPTR_W:0] errq_cnt_q;
	logic [QPTR_W-1:0] outq_wp_q;
	logic [QPTR_W-1:0] outq_rp_q;
	logic [QPTR_W-1:0] errq_wp_q;
	logic [QPTR_W-1:0] errq_rp_q;
	logic outq_full;
	logic errq_full;
	logic outq_pop;
	logic errq_pop;
	logic outq_ovf;
	logic errq_ovf;
	assign outq_full = outq_cnt_q == (QPTR_W+1)'(QDEPTH);
	assign errq_full = errq_cnt_q == (QPTR_W+1)'(QDEPTH);
	assign outq_pop = rd && adr == ser_pkg::OFF_OUTQ && outq_cnt_q != '0;
	assign errq_pop = rd && adr == ser_pkg::OFF_ERRQ && errq_cnt_q != '0;
	assign outq_ovf = outq_push_in.push && outq_full && !outq_pop;
	assign errq_ovf = errq_push_in.push && !errq_clear && errq_full && !errq_pop;

	always_ff @(posedge clk_in) begin
		if (!rst_n_in) begin
			outq_wp_q <= '0;
			outq_rp_q <= '0;
			outq_cnt_q <= '0;
		end else begin
			if (outq_push_in.push && !outq_ovf) begin
				outq_mem[outq_wp_q] <= outq_push_in.data;
				outq_wp_q <= outq_wp_q + 1'b1;
			end
			if (outq_pop) begin
				outq_rp_q <= outq_rp_q + 1'b1;
			end
			outq_cnt_q <= outq_cnt_q + (QPTR_W+1)'(outq_push_in.push && !outq_ovf)
				- (QPTR_W+1)'(outq_pop);
		end
	end

	// errors into error queue; a push with a clear survives the clear
	always_ff @(posedge clk_in) begin
		if (!rst_n_in) begin
			errq_wp_q <= '0;
			errq_rp_q <= '0;
			errq_cnt_q <= '0;
		end else if (errq_clear) begin
			errq_rp_q <= errq_wp_q;
			errq_cnt_q <= (QPTR_W+1)'(errq_push_in.push);
			if (errq_push_in.push) begin
				errq_mem[errq_wp_q] <= errq_push_in.data;
				errq_wp_q <= errq_wp_q + 1'b1;
			end
		end else begin
			if (errq_push_in.push && !errq_ovf) begin
				errq_mem[errq_wp_q] <= errq_push_in.data;
				errq_wp_q <= errq_wp_q + 1'b1;
			end
			if (errq_pop) begin
				errq_rp_q <= errq_rp_q + 1'b1;
			end
			errq_cnt_q <= errq_cnt_q + (QPTR_W+1)'(errq_push_in.push && !errq_ovf)
				- (QPTR_W+1)'(errq_pop);
		end
	end

	// =====================================================
	// status byte and service request
	logic [7:0] stb_d;
	logic [7:0] sre_q;
	logic srq_d;
	always_comb begin
		stb_d = 8'h00;
		stb_d[ser_pkg::STB_MEA] = sum[2];
		stb_d[ser_pkg::STB_QUE] = sum[3];
		stb_d[ser_pkg::STB_STD] = sum[0];
		stb_d[ser_pkg::STB_OPR] = sum[1];
		stb_d[ser_pkg::STB_OUTQ] = outq_cnt_q != '0;
		stb_d[ser_pkg::STB_ERRQ] = errq_cnt_q != '0;
		srq_d = |(stb_d & sre_q & ~(8'h01 << ser_pkg::STB_SRQ));
		stb_d[ser_pkg::STB_SRQ] = srq_d;
	end

	always_ff @(posedge clk_in) begin
		if (!rst_n_in) begin
			status_byte_out <= 8'h00;
			service_request_summary_bit_out <= 1'b0;
		end else begin
			status_byte_out <= stb_d;
			service_request_summary_bit_out <= srq_d;
		end
	end

	// service request enable, srq bit itself not enableable
	always_ff @(posedge clk_in) begin
		if (!rst_n_in) begin
			sre_q <= 8'h00;
		end else if (wr && adr == ser_pkg::OFF_SRE && lo_en) begin
			sre_q <= wb_dat_in[7:0] & ~(8'h01 << ser_pkg::STB_SRQ);
		end
	end

	// =====================================================
	// interrupts: sticky, write one to clear, set wins
	logic [2:0] irq_stat_q;
	logic [2:0] irq_mask_q;
	logic [2:0] irq_ev;
	logic [2:0] irq_clr;
	assign irq_ev = {errq_ovf, outq_ovf, srq_d && !service_request_summary_bit_out};
	assign irq_clr = (wr && adr == ser_pkg::OFF_IRQ_STAT && lo_en) ? wb_dat_in[2:0] : 3'h0;
	always_ff @(posedge clk_in) begin
		if (!rst_n_in) begin
			irq_stat_q <= 3'h0;
		end else begin
			irq_stat_q <= (irq_stat_q & ~irq_clr) | irq_ev;
		end
	end
	always_ff @(posedge clk_in) begin
		if (!rst_n_in) begin
			irq_mask_q <= 3'h0;
		end else if (wr && adr == ser_pkg::OFF_IRQ_MASK && lo_en) begin
			irq_mask_q <= wb_dat_in[2:0];
		end
	end
	always_ff @(posedge clk_in) begin
		if (!rst_n_in) begin
			irq_out <= 1'b0;
		end else begin
			irq_out <= |(((irq_stat_q & ~irq_clr) | irq_ev) & irq_mask_q);
		end
	end

	// =====================================================
	// read mux and ack; unmapped reads zero, writes ignored
	logic [31:0] rdat;
	always_comb begin
		rdat = 32'h0000_0000;
		case (adr)
			ser_pkg::OFF_STD_COND: rdat[REG_W-1:0] = cond_q[0];
			ser_pkg::OFF_STD_EVT: rdat[REG_W-1:0] = evt_q[0];
			ser_pkg::OFF_STD_EN: rdat[REG_W-1:0] = en_q[0];
			ser_pkg::OFF_OPR_COND: rdat[REG_W-1:0] = cond_q[1];
			ser_pkg::OFF_OPR_EVT: rdat[REG_W-1:0] = evt_q[1];
			ser_pkg::OFF_OPR_EN: rdat[REG_W-1:0] = en_q[1];
			ser_pkg::OFF_MEA_COND: rdat[REG_W-1:0] = cond_q[2];
			ser_pkg::OFF_MEA_EVT: rdat[REG_W-1:0] = evt_q[2];
			ser_pkg::OFF_MEA_EN: rdat[REG_W-1:0] = en_q[2];
			ser_pkg::OFF_QUE_COND: rdat[REG_W-1:0] = cond_q[3];
			ser_pkg::OFF_QUE_EVT: rdat[REG_W-1:0] = evt_q[3];
			ser_pkg::OFF_QUE_EN: rdat[REG_W-1:0] = en_q[3];
			ser_pkg::OFF_STB: rdat[7:0] = status_byte_out;
			ser_pkg::OFF_SRE: rdat[7:0] = sre_q;
			ser_pkg::OFF_OUTQ: rdat[REG_W-1:0] = outq_pop ? outq_mem[outq_rp_q] : '0;
			ser_pkg::OFF_ERRQ: rdat[REG_W-1:0] = errq_pop ? errq_mem[errq_rp_q] : '0;
			ser_pkg::OFF_IRQ_STAT: rdat[2:0] = irq_stat_q;
			ser_pkg::OFF_IRQ_MASK: rdat[2:0] = irq_mask_q;
			default: rdat = 32'h0000_0000;
		endcase
	end

	always_ff @(posedge clk_in) begin
		if (!rst_n_in) begin
			wb_ack_out <= 1'b0;
			wb_dat_out <= 32'h0000_0000;
		end else begin
			wb_ack_out <= acc;
			wb_dat_out <= rd ? rdat : 32'h0000_0000;
		end
	end
endmodule

`default_nettype wire

// ### verif/ser_host.sv
// host program model: classic wishbone single cycles
`timescale 1ns/1ns
`default_nettype none
module ser_host (
	input wire logic clk_in,
	input wire logic [31:0] wb_dat_in,
	input wire logic wb_ack_in,
	output logic [31:0] wb_adr_out,
	output logic [31:0] wb_dat_out,
	output logic [3:0] wb_sel_out,
	output logic wb_we_out,
	output logic wb_cyc_out,
	output logic wb_stb_out
);
	initial begin
		{wb_adr_out, wb_dat_out, wb_sel_out, wb_we_out, wb_cyc_out, wb_stb_out} = '0;
	end
	// ====
	// one transfer; waits for ack with no cycle count assumed
	task xfer(input logic w, input logic [7:0] a, input logic [15:0] d, output logic [31:0] q);
		@(posedge clk_in);
		wb_cyc_out <= 1'b1;
		wb_stb_out <= 1'b1;
		wb_we_out <= w;
		wb_adr_out <= {24'h0, a};
		wb_dat_out <= {16'h0, d};
		wb_sel_out <= 4'h3;
		// ack and read data are taken at the rising edge only
		@(posedge clk_in);
		while (wb_ack_in !== 1'b1) @(posedge clk_in);
		q = wb_dat_in;
		wb_cyc_out <= 1'b0;
		wb_stb_out <= 1'b0;
		// released lines must not look like the last request
		wb_adr_out <= ~wb_adr_out;
		wb_dat_out <= ~wb_dat_out;
	endtask
endmodule
`default_nettype wire

// ### verif/ser_top_monitor.sv
// port assertions for the status event reporting block
`timescale 1ns/1ns
`default_nettype none
module ser_monitor (
	input wire logic clk_in,
	input wire logic rst_n_in,
	input wire logic [31:0] wb_adr_in,
	input wire logic [31:0] wb_dat_in,
	input wire logic [3:0] wb_sel_in,
	input wire logic wb_we_in,
	input wire logic wb_cyc_in,
	input wire logic wb_stb_in,
	input wire logic [31:0] wb_dat_out,
	input wire logic wb_ack_out,
	input wire ser_pkg::ser_push_t outq_push_in,
	input wire ser_pkg::ser_push_t errq_push_in,
	input wire logic [7:0] status_byte_out,
	input wire logic service_request_summary_bit_out,
	input wire logic irq_out
);
	logic take;
	logic clr;
	assign take = wb_cyc_in && wb_stb_in && !wb_ack_out;
	assign clr = take && wb_we_in && wb_sel_in[0] && wb_adr_in[7:0] == ser_pkg::OFF_CMD
		&& (wb_dat_in[0] || wb_dat_in[2] || wb_dat_in[3]);
	default clocking cb @(posedge clk_in); endclocking
	default disable iff (!rst_n_in);
	// ====
	// properties
	property p_ack_pulse; wb_ack_out |=> !wb_ack_out; endproperty
	property p_ack_resp; take |=> wb_ack_out; endproperty
	property p_dat_idle; !wb_ack_out |-> wb_dat_out == 32'h0; endproperty
	property p_srq_copy; service_request_summary_bit_out == status_byte_out[ser_pkg::STB_SRQ];
	endproperty
	property p_rst_clear;
		disable iff (1'b0) !rst_n_in |=> status_byte_out == 8'h00 && !irq_out && !wb_ack_out;
	endproperty
	property p_outq_sum; outq_push_in.push |-> ##[1:3] status_byte_out[ser_pkg::STB_OUTQ];
	endproperty
	property p_errq_sum; errq_push_in.push |-> ##[1:3] status_byte_out[ser_pkg::STB_ERRQ];
	endproperty
	property p_err_clear; clr |-> ##[2:4] !status_byte_out[ser_pkg::STB_ERRQ]; endproperty
	a_ack_pulse: assert property (p_ack_pulse) else $error("ack wider than one cycle");
	a_ack_resp: assert property (p_ack_resp) else $error("request not acked");
	a_dat_idle: assert property (p_dat_idle) else $error("read data outside ack");
	a_srq_copy: assert property (p_srq_copy) else $error("service bit mismatch");
	a_rst_clear: assert property (p_rst_clear) else $error("outputs not cleared");
	a_outq_sum: assert property (p_outq_sum) else $error("output queue summary");
	a_errq_sum: assert property (p_errq_sum) else $error("error queue summary");
	a_err_clear: assert property (p_err_clear) else $error("error queue not emptied");
	c_write: cover property (take && wb_we_in);
	c_srq: cover property (service_request_summary_bit_out);
	c_irq: cover property (irq_out);
endmodule
bind ser_top ser_monitor i_mon (.clk_in, .rst_n_in, .wb_adr_in, .wb_dat_in, .wb_sel_in,
	.wb_we_in, .wb_cyc_in, .wb_stb_in, .wb_dat_out, .wb_ack_out, .outq_push_in,
	.errq_push_in, .status_byte_out, .service_request_summary_bit_out, .irq_out);
`default_nettype wire

// ### verif/tb_top.sv
// self-checking bench for the status event reporting block
`timescale 1ns/1ns
`default_nettype none
module tb_top;
	logic clk_in, rst_n_in, wb_we, wb_cyc, wb_stb, wb_ack, srq, irq;
	logic [31:0] wb_adr, wb_wdat, wb_rdat, rv;
	logic [3:0] wb_sel;
	logic [15:0] std_c, que_c, std_e, opr_e, mea_e, que_e;
	logic [7:0] sb, b;
	ser_pkg::ser_push_t oq, eq;
	int err_total, total_checks, cycles;
	initial begin
		clk_in = 1'b0;
		forever #25 clk_in = ~clk_in;
	end
	ser_top i_dut (.clk_in, .rst_n_in, .wb_adr_in(wb_adr), .wb_dat_in(wb_wdat),
		.wb_sel_in(wb_sel), .wb_we_in(wb_we), .wb_cyc_in(wb_cyc), .wb_stb_in(wb_stb),
		.wb_dat_out(wb_rdat), .wb_ack_out(wb_ack), .std_cond_in(std_c), .opr_cond_in(que_c),
		.mea_cond_in(std_c), .que_cond_in(que_c), .std_evt_in(std_e), .opr_evt_in(opr_e),
		.mea_evt_in(mea_e), .que_evt_in(que_e), .outq_push_in(oq), .errq_push_in(eq),
		.status_byte_out(sb), .service_request_summary_bit_out(srq), .irq_out(irq));
	ser_host i_host (.clk_in, .wb_dat_in(wb_rdat), .wb_ack_in(wb_ack), .wb_adr_out(wb_adr),
		.wb_dat_out(wb_wdat), .wb_sel_out(wb_sel), .wb_we_out(wb_we), .wb_cyc_out(wb_cyc),
		.wb_stb_out(wb_stb));
	// ====
	// helpers
	task end_sim;
		$display("checks %0d errors %0d", total_checks, err_total);
		if (err_total == 0 && total_checks > 0)
			$display("All checks passed");
		else
			$display("Checks failed");
		$finish;
	endtask
	task chk(input logic [31:0] g, input logic [31:0] e);
		total_checks++;
		if (g !== e) begin
			err_total++;
			$display("ERROR %0t got %h expected %h", $time, g, e);
		end
	endtask
	task wr(input logic [7:0] a, input logic [15:0] d);
		i_host.xfer(1'b1, a, d, rv);
	endtask
	task rc(input logic [7:0] a, input logic [31:0] e);
		i_host.xfer(1'b0, a, 16'h0, rv);
		chk(rv, e);
	endtask
	// summaries settle two cycles after their cause
	task sbc(input logic [7:0] e, input logic i);
		repeat (3) @(posedge clk_in);
		@(negedge clk_in);
		chk({22'h0, srq, irq, sb}, {22'h0, e[ser_pkg::STB_SRQ], i, e});
	endtask
	task qpush(input logic err, input logic [15:0] d);
		@(posedge clk_in);
		if (err) eq <= {1'b1, d};
		else oq <= {1'b1, d};
		@(posedge clk_in);
		eq <= '0;
		oq <= '0;
	endtask
	always @(posedge clk_in) begin
		cycles <= cycles + 1;
		if (cycles == 5000) begin
			err_total++;
			end_sim;
		end
	end
	// ====
	// sequence
	initial begin
		{rst_n_in, std_c, que_c, std_e, opr_e, mea_e, que_e, oq, eq} = '0;
		{err_total, total_checks, cycles} = '0;
		repeat (20) @(posedge clk_in);
		rst_n_in <= 1'b1;
		for (int a = 0; a <= 'h4c; a += 4) if (a != 'h38) rc(8'(a), 32'h0);
		for (int k = 0; k < 4; k++) begin
			b = 8'(12 * k);
			for (int j = 0; j < 12; j += 4) wr(b + 8'(j), 16'hffff);
			rc(b, 32'h0);
			rc(b + 8'h04, 32'h0);
			rc(b + 8'h08, 32'hffff);
		end
		wr(8'h30, 16'hffff);
		rc(8'h30, 32'h0);
		std_c <= 16'ha5c3;
		que_c <= 16'h5a3c;
		rc(8'h00, 32'ha5c3);
		rc(8'h0c, 32'h5a3c);
		rc(8'h18, 32'ha5c3);
		rc(8'h24, 32'h5a3c);
		@(posedge clk_in);
		{std_e, opr_e, mea_e, que_e} <= {16'h0001, 16'h0008, 16'h8000, 16'h0100};
		@(posedge clk_in);
		{std_e, opr_e, mea_e, que_e} <= '0;
		sbc(8'ha9, 1'b0);
		rc(8'h10, 32'h8);
		rc(8'h1c, 32'h8000);
		wr(8'h34, 16'h00ff);
		sbc(8'he9, 1'b0);
		wr(8'h48, 16'h0007);
		sbc(8'he9, 1'b1);
		wr(8'h48, 16'h0000);
		wr(8'h44, 16'h0001);
		sbc(8'he9, 1'b0);
		wr(8'h34, 16'h0000);
		sbc(8'ha9, 1'b0);
		wr(8'h14, 16'h0000);
		sbc(8'h29, 1'b0);
		qpush(1'b0, 16'h1234);
		qpush(1'b1, 16'h0bad);
		sbc(8'h3d, 1'b0);
		rc(8'h3c, 32'h1234);
		wr(8'h38, 16'h0030);
		sbc(8'h2d, 1'b0);
		wr(8'h38, 16'h0002);
		rc(8'h20, 32'h0);
		sbc(8'h24, 1'b0);
		wr(8'h38, 16'h0001);
		rc(8'h04, 32'h0);
		rc(8'h08, 32'hffff);
		sbc(8'h00, 1'b0);
		for (int c = 2; c < 4; c++) begin
			qpush(1'b1, 16'h0e00);
			wr(8'h38, 16'(1 << c));
			rc(8'h40, 32'h0);
		end
		// one word past the depth overflows each queue
		for (int n = 0; n <= ser_pkg::QDEPTH; n++) qpush(1'b0, 16'(n + 1));
		for (int n = 0; n <= ser_pkg::QDEPTH; n++) qpush(1'b1, 16'(n + 1));
		wr(8'h48, 16'h0006);
		sbc(8'h14, 1'b1);
		rc(8'h44, 32'h6);
		rc(8'h3c, 32'h1);
		rc(8'h40, 32'h1);
		wr(8'h44, 16'h0006);
		sbc(8'h14, 1'b0);
		wr(8'h08, 16'h0000);
		rc(8'h08, 32'h0);
		end_sim;
	end
endmodule
`default_nettype wire
